// ===== pin_fault_supervisor.sv
/*
 * Pin fault and thermal supervisor: on a fault it stops switching and asks
 * for a lockout cycle or a long fault restart delay.
 * Assumes synchronous gatePulse and supplyOn; arst_n is the supply lockout.
 */
`default_nettype none
module pin_fault_supervisor #(
    parameter int unsigned FAULT_RESTART_CYCLES = pin_fault_pkg::FAULT_RESTART_CYC,
    parameter int unsigned DISCHARGE_OV_CYCLES = pin_fault_pkg::DISCHARGE_OV_CYC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire pin_fault_pkg::cmp_flags_s cmpFlags,
    input wire logic supplyOn,
    input wire logic gatePulse,
    input wire logic deviceTypeSi,
    output pin_fault_pkg::sup_ctrl_s ctrl_r
);
    // synchronised comparator flags
    pin_fault_pkg::cmp_flags_s flags;
    logic [pin_fault_pkg::CMP_FLAGS_W-1:0] flagsRaw;

    pin_fault_pkg::sup_state_e state_r;
    pin_fault_pkg::sup_state_e state_nxt;
    pin_fault_pkg::sup_ctrl_s ctrl_nxt;

    logic gatePrev_r; // gate level one cycle ago, for edges
    logic supplyPrev_r; // supply level one cycle ago, for its fall
    logic firstPending_r; // first pulse after start-up not yet finished
    logic delayDone_r; // restart delay has run out
    logic [pin_fault_pkg::ON_TIME_W-1:0] onTime_r; // first pulse on-time
    logic [pin_fault_pkg::TIMER_W-1:0] timer_r; // check and restart timer
    logic [pin_fault_pkg::TIMER_W-1:0] dischargeCnt_r; // discharge overvoltage time
    logic csOpenTrip;
    logic regOvTrip;

    // comparator flags are asynchronous to the clock
    flag_sync #(
        .WIDTH(pin_fault_pkg::CMP_FLAGS_W)
    ) u_flag_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async(cmpFlags),
        .synced(flagsRaw)
    );
    assign flags = flagsRaw; // [R16]

    // saturating increment of the long timers
    function automatic logic [pin_fault_pkg::TIMER_W-1:0] timerInc(
        input logic [pin_fault_pkg::TIMER_W-1:0] value
    );
        timerInc = (&value) ? value : value + 1'b1;
    endfunction

    // state decode
    wire logic inCheck = (state_r == pin_fault_pkg::ST_CHECK);
    wire logic inRun = (state_r == pin_fault_pkg::ST_RUN);
    wire logic inDelay = (state_r == pin_fault_pkg::ST_DELAY);
    wire logic inLockout = (state_r == pin_fault_pkg::ST_LOCKOUT);

    // gate and supply edges
    wire logic gateFall = gatePrev_r & ~gatePulse;
    wire logic supplyFall = supplyPrev_r & ~supplyOn;

    // first pulse on-time limit by device type and demag range
    wire logic [pin_fault_pkg::ON_TIME_W-1:0] limitSi =
        pin_fault_pkg::ON_TIME_W'(pin_fault_pkg::FIRST_SI_CYC);
    wire logic [pin_fault_pkg::ON_TIME_W-1:0] limitGanLong =
        pin_fault_pkg::ON_TIME_W'(pin_fault_pkg::FIRST_GL_CYC);
    wire logic [pin_fault_pkg::ON_TIME_W-1:0] limitGanShort =
        pin_fault_pkg::ON_TIME_W'(pin_fault_pkg::FIRST_GS_CYC);
    wire logic [pin_fault_pkg::ON_TIME_W-1:0] limitGan =
        flags.demagRangeHigh ? limitGanLong : limitGanShort; // [R6]
    wire logic [pin_fault_pkg::ON_TIME_W-1:0] firstLimit =
        deviceTypeSi ? limitSi : limitGan; // [R5]

    // short trips once the first pulse is still high past its limit
    wire logic csShortTrip =
        inRun & firstPending_r & gatePulse & (onTime_r >= firstLimit); // [R4]

    // regulator check instant, 10 us after the supply turned on
    wire logic checkDone =
        (timer_r >= pin_fault_pkg::TIMER_W'(pin_fault_pkg::REG_CHECK_CYC - 1)); // [R8]
    wire logic progPinFault = flags.demagPinFault | flags.delayPinFault; // [R12]
    wire logic regLowFault = flags.regBelowCheck; // [R8]

    // discharge overvoltage must stand continuously for its whole time
    wire logic dischargeTrip = flags.dischargeOv &
        (dischargeCnt_r >= pin_fault_pkg::TIMER_W'(DISCHARGE_OV_CYCLES - 1)); // [R10]

    wire logic restartDone =
        (timer_r >= pin_fault_pkg::TIMER_W'(FAULT_RESTART_CYCLES - 1));

    // consecutive pulse counters are cleared outside switching
    wire logic countClear = ~inRun; // [R15]

    // current sense at or above overcurrent, three pulses in a row
    pulse_fault_counter #(
        .COUNT_W(pin_fault_pkg::PULSE_CNT_W),
        .TRIP_COUNT(pin_fault_pkg::PULSE_TRIP_COUNT)
    ) u_cs_open (
        .clock(clock),
        .arst_n(arst_n),
        .clear(countClear),
        .pulseActive(gatePulse),
        .pulseEnd(gateFall),
        .condition(flags.senseOverCurrent),
        .trip(csOpenTrip)
    );

    // sense regulator overvoltage, three pulses in a row
    pulse_fault_counter #(
        .COUNT_W(pin_fault_pkg::PULSE_CNT_W),
        .TRIP_COUNT(pin_fault_pkg::PULSE_TRIP_COUNT)
    ) u_reg_ov (
        .clock(clock),
        .arst_n(arst_n),
        .clear(countClear),
        .pulseActive(gatePulse),
        .pulseEnd(gateFall),
        .condition(flags.regOverVoltage),
        .trip(regOvTrip)
    );

    // next state; every fault path ends back in off, never a latch
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pin_fault_pkg::ST_OFF: begin
                // without a supply turn-on nothing is ever enabled
                if (supplyOn) begin
                    state_nxt = pin_fault_pkg::ST_CHECK; // [R11]
                end
            end
            pin_fault_pkg::ST_CHECK: begin
                if (!supplyOn) begin
                    state_nxt = pin_fault_pkg::ST_OFF;
                end else if (flags.overTemp) begin
                    state_nxt = pin_fault_pkg::ST_LOCKOUT; // [R2]
                end else if (checkDone && (regLowFault || progPinFault)) begin
                    state_nxt = pin_fault_pkg::ST_LOCKOUT; // [R8] [R13]
                end else if (checkDone) begin
                    state_nxt = pin_fault_pkg::ST_RUN;
                end
            end
            pin_fault_pkg::ST_RUN: begin
                if (flags.overTemp || regOvTrip || dischargeTrip) begin
                    state_nxt = pin_fault_pkg::ST_LOCKOUT; // [R1] [R9] [R10]
                end else if (csShortTrip || csOpenTrip) begin
                    state_nxt = pin_fault_pkg::ST_DELAY; // [R5] [R7]
                end else if (!supplyOn) begin
                    state_nxt = pin_fault_pkg::ST_OFF;
                end
            end
            pin_fault_pkg::ST_DELAY: begin
                // supply cycles during the delay are ignored
                if (delayDone_r && supplyFall) begin
                    state_nxt = pin_fault_pkg::ST_OFF; // [R14] [R3]
                end
            end
            pin_fault_pkg::ST_LOCKOUT: begin
                if (!supplyOn) begin
                    state_nxt = pin_fault_pkg::ST_OFF; // [R3]
                end
            end
            default: begin
                state_nxt = pin_fault_pkg::ST_OFF;
            end
        endcase
    end

    // controls follow the next state so outputs come straight from flops
    wire logic goRun = (state_nxt == pin_fault_pkg::ST_RUN);
    wire logic goDelay = (state_nxt == pin_fault_pkg::ST_DELAY);
    wire logic goLockout = (state_nxt == pin_fault_pkg::ST_LOCKOUT);
    wire logic [3:0] runCause =
        flags.overTemp ? pin_fault_pkg::CAUSE_THERMAL :
        regOvTrip ? pin_fault_pkg::CAUSE_REG_OV :
        dischargeTrip ? pin_fault_pkg::CAUSE_DISCHARGE_OV :
        csShortTrip ? pin_fault_pkg::CAUSE_CS_SHORT :
        pin_fault_pkg::CAUSE_CS_OPEN;
    wire logic [3:0] checkCause =
        flags.overTemp ? pin_fault_pkg::CAUSE_THERMAL :
        regLowFault ? pin_fault_pkg::CAUSE_REG_LOW :
        pin_fault_pkg::CAUSE_PROG_PIN;
    wire logic faultEntry = (goLockout && !inLockout) || (goDelay && !inDelay);

    always_comb begin
        ctrl_nxt = ctrl_r;
        ctrl_nxt.switchEnable = goRun;
        ctrl_nxt.gateTerminate = csShortTrip; // [R5]
        ctrl_nxt.lockoutRequest = goLockout | goDelay; // [R1] [R13]
        ctrl_nxt.restartDelay = goDelay;
        if (faultEntry) begin
            ctrl_nxt.faultCause = inRun ? runCause : checkCause;
        end
    end

    // state and control registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= pin_fault_pkg::ST_OFF;
            ctrl_r <= pin_fault_pkg::CTRL_RESET;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // edge history
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gatePrev_r <= 1'b0;
            supplyPrev_r <= 1'b0;
        end else begin
            gatePrev_r <= gatePulse;
            supplyPrev_r <= supplyOn;
        end
    end

    // one shared timer: start check in check, restart delay in delay
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timer_r <= '0;
            delayDone_r <= 1'b0;
        end else if (inCheck || inDelay) begin
            timer_r <= timerInc(timer_r);
            delayDone_r <= delayDone_r | (inDelay & restartDone); // [R14]
        end else begin
            timer_r <= '0;
            delayDone_r <= 1'b0;
        end
    end

    // first pulse on-time, measured once per start-up only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            firstPending_r <= 1'b0;
            onTime_r <= '0;
        end else if (!inRun) begin
            firstPending_r <= 1'b1; // re-armed for the next start-up
            onTime_r <= '0;
        end else if (gateFall) begin
            firstPending_r <= 1'b0; // [R4]
        end else if (firstPending_r && gatePulse && !(&onTime_r)) begin
            onTime_r <= onTime_r + 1'b1;
        end
    end

    // discharge overvoltage duration; a dip restarts the count
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dischargeCnt_r <= '0;
        end else if (inRun && flags.dischargeOv) begin
            dischargeCnt_r <= timerInc(dischargeCnt_r); // [R10]
        end else begin
            dischargeCnt_r <= '0;
        end
    end

endmodule
`default_nettype wire

// ===== pin_fault_pkg.sv
/*
 * Shared constants and carrier types of the pin fault protection supervisor.
 * Assumes one 25 MHz clock and an asynchronous, active low supply lockout reset.
 */
// Operation
// [R1] over-temperature starts lockout reset then restart
// [R2] still hot after lockout: repeat lockout cycle
// [R3] every pin fault recovers automatically, never latches
// [R4] short check times only first gate pulse
// [R5] select high: first pulse over 2us trips
// [R6] select low: limit 2us or 1us by range
// [R7] sense at overcurrent three pulses: restart delay
// [R8] 10us after turn-on, low regulator: lockout
// [R9] regulator overvoltage three pulses: stop, lockout
// [R10] discharge overvoltage for 750us: stop, lockout
// [R11] no supply turn-on: no gate pulses ever
// [R12] program pins checked open/short before switching
// [R13] program pin fault: block switching, one lockout
// [R14] after restart delay, wait for supply turn-off
// [R15] pulse counters clear on clean pulse, lockout
// [R16] comparator flags synchronised before use
`default_nettype none
package pin_fault_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
    localparam int unsigned FIRST_LIMIT_SI_NS = 2000;
    localparam int unsigned FIRST_LIMIT_GAN_LONG_NS = 2000;
    localparam int unsigned FIRST_LIMIT_GAN_SHORT_NS = 1000;
    localparam int unsigned REG_CHECK_NS = 10000;
    localparam int unsigned DISCHARGE_OV_US = 750;
    localparam int unsigned FAULT_RESTART_DELAY_MS = 1500;
    // limits trip on exceeding the time: a least time, so round up
    localparam int unsigned FIRST_SI_CYC = (FIRST_LIMIT_SI_NS * CLK_KHZ + 999999) / 1000000;
    localparam int unsigned FIRST_GL_CYC = (FIRST_LIMIT_GAN_LONG_NS * CLK_KHZ + 999999) / 1000000;
    localparam int unsigned FIRST_GS_CYC = (FIRST_LIMIT_GAN_SHORT_NS * CLK_KHZ + 999999) / 1000000;
    localparam int unsigned REG_CHECK_CYC = (REG_CHECK_NS * CLK_KHZ + 999999) / 1000000;
    localparam int unsigned DISCHARGE_OV_CYC = (DISCHARGE_OV_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned FAULT_RESTART_CYC = FAULT_RESTART_DELAY_MS * CLK_KHZ;
    // widths
    localparam int unsigned ON_TIME_W = 7;
    localparam int unsigned TIMER_W = 26;
    localparam int unsigned PULSE_CNT_W = 2;
    localparam logic [PULSE_CNT_W-1:0] PULSE_TRIP_COUNT = 2'h3;
    // fault cause codes shown on the status output
    localparam logic [3:0] CAUSE_NONE = 4'h0;
    localparam logic [3:0] CAUSE_THERMAL = 4'h1;
    localparam logic [3:0] CAUSE_CS_SHORT = 4'h2;
    localparam logic [3:0] CAUSE_CS_OPEN = 4'h3;
    localparam logic [3:0] CAUSE_REG_LOW = 4'h4;
    localparam logic [3:0] CAUSE_REG_OV = 4'h5;
    localparam logic [3:0] CAUSE_PROG_PIN = 4'h6;
    localparam logic [3:0] CAUSE_DISCHARGE_OV = 4'h7;
    // supervisor states, one-hot
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_CHECK = 5'h02,
        ST_RUN = 5'h04,
        ST_DELAY = 5'h08,
        ST_LOCKOUT = 5'h10
    } sup_state_e;
    // comparator flags, active high, asynchronous
    typedef struct packed {
        logic overTemp;          // junction over-temperature
        logic senseOverCurrent;  // current sense at or above overcurrent level
        logic regBelowCheck;     // sense regulator pin below start check level
        logic regOverVoltage;    // sense regulator pin above overvoltage level
        logic dischargeOv;       // discharge sense pin above its threshold
        logic demagPinFault;     // demag program pin open or short
        logic delayPinFault;     // zvs delay program pin open or short
        logic demagRangeHigh;    // demag resistance at or above range threshold
    } cmp_flags_s;
    localparam int unsigned CMP_FLAGS_W = $bits(cmp_flags_s);
    // controls to the gate pulse generator and supply logic
    typedef struct packed {
        logic switchEnable;      // gate pulses allowed
        logic gateTerminate;     // end the present gate pulse now
        logic lockoutRequest;    // hold switching off, let the supply run down
        logic restartDelay;      // fault restart delay running
        logic [3:0] faultCause;  // last fault seen
    } sup_ctrl_s;
    localparam sup_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 4'h0};
endpackage
`default_nettype wire

// ===== flag_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of comparator flags.
 * Assumes the flags change slowly against the clock; bits are synchronised
 * independently, so a bundle may take one cycle to line up.
 */
`default_nettype none
module flag_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_r; // first stage, read by the second stage only
    logic [WIDTH-1:0] hold_r; // second stage
    // both stages clear on lockout reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            hold_r <= '0;
        end else begin
            meta_r <= async; // [R16]
            hold_r <= meta_r;
        end
    end
    assign synced = hold_r;
endmodule
`default_nettype wire

// ===== pulse_fault_counter.sv
/*
 * Counts consecutive gate pulses during which a fault condition was seen.
 * Assumes pulseEnd is a one-cycle pulse at the falling edge of a gate pulse.
 */
`default_nettype none
module pulse_fault_counter #(
    parameter int unsigned COUNT_W = 2,
    parameter logic [COUNT_W-1:0] TRIP_COUNT = 2'h3
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic pulseActive,
    input wire logic pulseEnd,
    input wire logic condition,
    output logic trip
);
    logic [COUNT_W-1:0] count_r; // consecutive faulty pulses
    logic seen_r; // condition seen during the present pulse
    logic trip_r;
    wire logic faultyPulse = seen_r | condition;
    wire logic [COUNT_W-1:0] countInc = count_r + 1'b1;
    // the condition may be brief, so it is caught anywhere inside the pulse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            seen_r <= 1'b0;
        end else if (clear || pulseEnd) begin
            seen_r <= 1'b0;
        end else if (pulseActive && condition) begin
            seen_r <= 1'b1;
        end
    end
    // count at each pulse end, start over on a clean pulse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
            trip_r <= 1'b0;
        end else if (clear) begin
            count_r <= '0; // [R15]
            trip_r <= 1'b0;
        end else if (pulseEnd) begin
            count_r <= faultyPulse ? countInc : '0; // [R15]
            trip_r <= faultyPulse && (countInc == TRIP_COUNT);
        end else begin
            trip_r <= 1'b0;
        end
    end
    assign trip = trip_r;
endmodule
`default_nettype wire

// ===== gate_pulse_model.sv
/*
 * Behavioural gate pulse generator facing the pin fault supervisor.
 * Assumes the supervisor's clock and reset; pulses only while switching is enabled.
 */
`default_nettype none
module gate_pulse_model #(
    parameter int unsigned OFF_CYCLES = 10
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic switchEnable,
    input wire logic gateTerminate,
    input wire logic [7:0] firstOn,
    input wire logic [7:0] laterOn,
    output logic gatePulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic first_r; // next pulse is the first since enable
    logic [7:0] cnt_r; // cycles spent in the present phase
    // first pulse length apart, to provoke the short check alone
    wire logic [7:0] onLen = first_r ? firstOn : laterOn;
    // low phase first, then pulses; a terminate cuts the pulse short
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n || !switchEnable) begin
            gatePulse <= 1'b0;
            cnt_r <= 8'h0;
            first_r <= 1'b1;
        end else if (gatePulse && (gateTerminate || cnt_r >= onLen)) begin
            gatePulse <= 1'b0;
            cnt_r <= 8'h1;
            first_r <= 1'b0;
        end else if (!gatePulse && cnt_r >= 8'(OFF_CYCLES)) begin
            gatePulse <= 1'b1;
            cnt_r <= 8'h1;
        end else begin
            cnt_r <= cnt_r + 8'h1;
        end
    end
endmodule
`default_nettype wire

// ===== pin_fault_supervisor_monitor.sv
/*
 * Port checker of the pin fault supervisor, bound to its top module.
 * Assumes one clock domain and the asynchronous supply lockout reset.
 */
`default_nettype none
module pin_fault_supervisor_monitor #(
    parameter int unsigned FAULT_RESTART_CYCLES = 200,
    parameter int unsigned DISCHARGE_OV_CYCLES = 40
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire pin_fault_pkg::cmp_flags_s cmpFlags,
    input wire logic supplyOn,
    input wire logic gatePulse,
    input wire logic deviceTypeSi,
    input wire pin_fault_pkg::sup_ctrl_s ctrl_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // raw input run lengths; raw leads the synced copy
    logic [31:0] onCnt_r, dchCnt_r, dlyCnt_r, supCnt_r;
    // first pulse limit
    wire logic [31:0] limit = deviceTypeSi ? pin_fault_pkg::FIRST_SI_CYC :
        cmpFlags.demagRangeHigh ? pin_fault_pkg::FIRST_GL_CYC : pin_fault_pkg::FIRST_GS_CYC;
    // run counters, cleared when their level drops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            onCnt_r <= '0;
            dchCnt_r <= '0;
            dlyCnt_r <= '0;
            supCnt_r <= '0;
        end else begin
            onCnt_r <= gatePulse ? onCnt_r + 32'h1 : '0;
            dchCnt_r <= cmpFlags.dischargeOv ? dchCnt_r + 32'h1 : '0;
            dlyCnt_r <= ctrl_r.restartDelay ? dlyCnt_r + 32'h1 : '0;
            supCnt_r <= supplyOn ? supCnt_r + 32'h1 : '0;
        end
    end
    a_short_limit: assert property ($rose(ctrl_r.gateTerminate) |-> $past(onCnt_r) >= $past(limit) - 1)
        else $error("gate pulse cut before its limit");
    a_check_time: assert property ($rose(ctrl_r.switchEnable) |-> $past(supCnt_r) >= pin_fault_pkg::REG_CHECK_CYC)
        else $error("switching began before the start check");
    a_check_clean: assert property ($rose(ctrl_r.switchEnable) |-> !$past(cmpFlags.regBelowCheck, 3) && !$past(cmpFlags.demagPinFault, 3) && !$past(cmpFlags.delayPinFault, 3))
        else $error("switching began despite a start check fault");
    a_hot_stops: assert property ($rose(cmpFlags.overTemp) ##0 ctrl_r.switchEnable |-> ##[1:4] (ctrl_r.lockoutRequest && !ctrl_r.switchEnable))
        else $error("over temperature did not stop switching");
    a_hot_no_start: assert property (cmpFlags.overTemp[*4] |-> !$rose(ctrl_r.switchEnable))
        else $error("switching began while hot");
    a_delay_locks: assert property (ctrl_r.restartDelay |-> ctrl_r.lockoutRequest && !ctrl_r.switchEnable)
        else $error("restart delay without switching stopped");
    a_delay_hold: assert property ($fell(ctrl_r.restartDelay) |-> $past(dlyCnt_r) >= FAULT_RESTART_CYCLES - 2)
        else $error("restart delay ended early");
    a_lock_holds: assert property (ctrl_r.lockoutRequest && supplyOn |=> ctrl_r.lockoutRequest)
        else $error("lockout released with supply still on");
    a_discharge_time: assert property ($rose(ctrl_r.faultCause == pin_fault_pkg::CAUSE_DISCHARGE_OV) |-> $past(dchCnt_r) >= DISCHARGE_OV_CYCLES)
        else $error("discharge fault raised too soon");
    a_no_supply: assert property (!supplyOn[*3] |-> !ctrl_r.switchEnable)
        else $error("switching without supply");
endmodule
bind pin_fault_supervisor pin_fault_supervisor_monitor #(
    .FAULT_RESTART_CYCLES(FAULT_RESTART_CYCLES),
    .DISCHARGE_OV_CYCLES(DISCHARGE_OV_CYCLES)
) monitor (
    .clock(clock),
    .arst_n(arst_n),
    .cmpFlags(cmpFlags),
    .supplyOn(supplyOn),
    .gatePulse(gatePulse),
    .deviceTypeSi(deviceTypeSi),
    .ctrl_r(ctrl_r)
);
`default_nettype wire

// ===== tb.sv
/*
 * Self-checking bench of the pin fault supervisor with a gate pulse model.
 * Assumes shortened restart and discharge counts; flags held steady around checks.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // one case: start flags, run flags, select, pulse lengths, expected outcome
    typedef struct packed {
        logic [7:0] chk, run;
        logic si;
        logic [7:0] on1, on2;
        logic fault, dly;
        logic [3:0] cause;
    } row_s;
    logic clock, arst_n, supplyOn, deviceTypeSi, gatePulse, gPrev;
    logic [7:0] firstOn, laterOn;
    pin_fault_pkg::cmp_flags_s cmpFlags;
    pin_fault_pkg::sup_ctrl_s ctrl_r;
    int n_fail, n_tests;
    // clean rows keep the held cause
    row_s rows [14] = '{
        '{8'h20, 8'h00, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h4},
        '{8'h04, 8'h00, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h6},
        '{8'h02, 8'h00, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h6},
        '{8'h80, 8'h00, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h1},
        '{8'h00, 8'h80, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h1},
        '{8'h00, 8'h40, 1'b0, 8'd10, 8'd10, 1'b1, 1'b1, 4'h3},
        '{8'h00, 8'h10, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h5},
        '{8'h00, 8'h08, 1'b0, 8'd10, 8'd10, 1'b1, 1'b0, 4'h7},
        '{8'h00, 8'h00, 1'b1, 8'd60, 8'd10, 1'b1, 1'b1, 4'h2},
        '{8'h01, 8'h01, 1'b0, 8'd60, 8'd10, 1'b1, 1'b1, 4'h2},
        '{8'h00, 8'h00, 1'b0, 8'd30, 8'd10, 1'b1, 1'b1, 4'h2},
        '{8'h01, 8'h01, 1'b0, 8'd30, 8'd10, 1'b0, 1'b0, 4'h2},
        '{8'h00, 8'h00, 1'b1, 8'd40, 8'd40, 1'b0, 1'b0, 4'h2},
        '{8'h00, 8'h00, 1'b0, 8'd10, 8'd60, 1'b0, 1'b0, 4'h2}};
    pin_fault_supervisor #(.FAULT_RESTART_CYCLES(200), .DISCHARGE_OV_CYCLES(40)) uut (
        .clock(clock), .arst_n(arst_n), .cmpFlags(cmpFlags), .supplyOn(supplyOn),
        .gatePulse(gatePulse), .deviceTypeSi(deviceTypeSi), .ctrl_r(ctrl_r));
    gate_pulse_model model (.clock(clock), .arst_n(arst_n), .switchEnable(ctrl_r.switchEnable),
        .gateTerminate(ctrl_r.gateTerminate), .firstOn(firstOn), .laterOn(laterOn),
        .gatePulse(gatePulse));
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic end_of_test();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // sel 0: started or locked, 1: not switching, 2: the four control bits idle, cause not checked
    function automatic logic hit(input int sel);
        if (sel == 0) return (ctrl_r.switchEnable | ctrl_r.lockoutRequest) === 1'b1;
        if (sel == 1) return ctrl_r.switchEnable === 1'b0;
        return ctrl_r[7:4] === 4'h0;
    endfunction
    // bounded wait; clean rows may run out on purpose
    task automatic await(input int sel, input int lim, input logic must);
        int k;
        k = 0;
        while (k < lim && !hit(sel)) begin
            @(posedge clock);
            k++;
        end
        if (k >= lim && must) begin
            check("wait", 8'h1, 8'h0);
            end_of_test();
        end
    endtask
    // counts gate falls, seen one edge late, bounded
    task automatic falls(input int n);
        int k;
        k = 0;
        for (int j = 0; j < 3000 && k < n; j++) begin
            @(posedge clock);
            if (gPrev && !gatePulse) k++;
            gPrev = gatePulse;
        end
        if (k < n) begin
            check("falls", 8'h1, 8'h0);
            end_of_test();
        end
    endtask
    initial begin
        arst_n = 1'b0;
        supplyOn = 1'b0;
        deviceTypeSi = 1'b0;
        cmpFlags = '0;
        firstOn = 8'd10;
        laterOn = 8'd10;
        gPrev = 1'b0;
        n_fail = 0;
        n_tests = 0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (300) @(posedge clock);
        check("idle", 8'h00, {ctrl_r[7:4], 3'h0, gatePulse});
        $display("idle test done");
        // flags settle before the supply comes up
        for (int i = 0; i < 14; i++) begin
            cmpFlags <= rows[i].chk;
            deviceTypeSi <= rows[i].si;
            firstOn <= rows[i].on1;
            laterOn <= rows[i].on2;
            repeat (4) @(posedge clock);
            supplyOn <= 1'b1;
            @(posedge clock);
            await(0, 400, 1'b1);
            if (ctrl_r.switchEnable === 1'b1) cmpFlags <= rows[i].run;
            await(1, 600, rows[i].fault);
            repeat (3) @(posedge clock);
            check("row", {~rows[i].fault, rows[i].fault, rows[i].dly, rows[i].cause}, {ctrl_r[7], ctrl_r[5:0]});
            repeat (250) @(posedge clock);
            supplyOn <= 1'b0;
            cmpFlags <= '0;
            @(posedge clock);
            await(2, 50, 1'b1);
            $display("row %0d done", i);
        end
        // a clean pulse pair restarts the count
        firstOn <= 8'd10;
        laterOn <= 8'd10;
        deviceTypeSi <= 1'b0;
        supplyOn <= 1'b1;
        @(posedge clock);
        await(0, 400, 1'b1);
        for (int p = 0; p < 3; p++) begin
            cmpFlags <= p[0] ? 8'h00 : 8'h40;
            falls(2);
        end
        check("count", 8'h80, {ctrl_r[7], 7'h0});
        falls(1);
        repeat (4) @(posedge clock);
        check("open", 8'hf3, {ctrl_r[5:4], ctrl_r[5:4], ctrl_r[3:0]});
        $display("count test done");
        // an early supply fall is ignored
        supplyOn <= 1'b0;
        repeat (250) @(posedge clock);
        check("hold", 8'h01, {7'h0, ctrl_r.restartDelay});
        supplyOn <= 1'b1;
        @(posedge clock);
        supplyOn <= 1'b0;
        cmpFlags <= '0;
        @(posedge clock);
        await(2, 20, 1'b1);
        $display("delay test done");
        // reset while switching
        supplyOn <= 1'b1;
        @(posedge clock);
        await(0, 400, 1'b1);
        arst_n <= 1'b0;
        @(posedge clock);
        check("reset", 8'h00, ctrl_r);
        arst_n <= 1'b1;
        supplyOn <= 1'b0;
        repeat (2) @(posedge clock);
        check("release", 8'h00, ctrl_r);
        $display("reset test done");
        end_of_test();
    end
endmodule
`default_nettype wire
